//--- hdl/sfae_params.svh
// Named constants for the serial flash address extension block.
// Assumes inclusion by bare name from the core module.
`ifndef SFAE_PARAMS_SVH
`define SFAE_PARAMS_SVH

// Bank register layout and reset value
`define SFAE_EXT_BIT 3'd7
`define SFAE_BANK_RESET 8'h00

// Last bit index of each serial field, counted from zero
`define SFAE_LAST_BYTE 5'd7
`define SFAE_LAST_ADDR24 5'd23
`define SFAE_LAST_ADDR32 5'd31

// Address field positions
`define SFAE_HI_MSB 31
`define SFAE_HI_LSB 24
`define SFAE_LO_MSB 23
`define SFAE_HI_ZERO 8'h00

// One-time space size in bytes
`define SFAE_OTP_SIZE 32'h0000_0400

// Command codes; plain defaults, adjustable per product
`define SFAE_OPC_READ 8'h03
`define SFAE_OPC_PROG 8'h02
`define SFAE_OPC_READ4 8'h13
`define SFAE_OPC_PROG4 8'h12
`define SFAE_OPC_OTP_READ 8'h4B
`define SFAE_OPC_OTP_PROG 8'h42
`define SFAE_OPC_BANK_WR 8'h17
`define SFAE_OPC_BANK_RD 8'h16

// Synchroniser reset pattern for {sck, cs_n, si}: select idles high
`define SFAE_LINK_IDLE 3'b010

`endif

//--- hdl/sfae_pkg.sv
// Types shared by the address extension core and the testbench.
// Needs no constants header; only the core module includes it.
package sfae_pkg;

  // Link pins as seen at the device boundary
  typedef struct packed {
    logic sck; // Serial clock from the host
    logic cs_n; // Chip select, active low
    logic si; // Serial data into the device
  } sfae_link_s;

  // Frame phases of the command decoder
  typedef enum logic [2:0] {
    SFAE_OPC,
    SFAE_ADDR,
    SFAE_BANK_IN,
    SFAE_BANK_OUT,
    SFAE_SKIP
  } sfae_phase_e;

  // Address space a command targets
  typedef enum logic {
    SFAE_MAIN,
    SFAE_OTP
  } sfae_space_e;

  // Decoded command with its effective address
  typedef struct packed {
    logic valid; // One-cycle strobe
    logic [7:0] opcode; // Received command code
    sfae_space_e space; // Target address space
    logic wide; // Four address bytes were taken
    logic otp_ok; // Address inside the one-time space
    logic [31:0] addr; // Effective byte address
  } sfae_cmd_s;

  // Whole state of the core
  typedef struct packed {
    sfae_phase_e phase;
    logic [4:0] bitcnt; // Bits taken in the current field
    logic [4:0] last_bit; // Index of the final address bit
    logic [31:0] shreg; // Incoming serial bits
    logic [7:0] shout; // Outgoing bank image
    logic [7:0] opcode;
    logic [7:0] bank; // Bank register, mode bit on top
    logic sck_prev; // Previous synchronised clock
    logic so; // Serial output level
    logic so_oe; // Serial output enable
    sfae_cmd_s cmd;
  } sfae_state_s;

endpackage : sfae_pkg

//--- hdl/sfae_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the reset pattern matches the idle level of the pins.
`timescale 1ns/100ps
module sfae_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  // Both stages in one state word
  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by the second
    logic [W-1:0] sync; // Second stage, safe to use
  } sfae_sync_s;

  sfae_sync_s q_q;
  sfae_sync_s q_d;

  // Next stage values
  always_comb begin
    q_d.meta = d_in;
    q_d.sync = q_q.meta;
  end

  // Stage registers, constant reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_q <= {RST_VAL, RST_VAL};
    end else begin
      q_q <= q_d;
    end
  end

  assign q_out = q_q.sync;

endmodule : sfae_sync

//--- hdl/sfae_core.sv
// Command and address formation for a serial flash with 32-bit addressing.
// Assumes serial mode 0 pins, sampled by clk_in far faster than the link clock.
`timescale 1ns/100ps
`include "sfae_params.svh"
module sfae_core
  import sfae_pkg::*;
#(
  parameter bit DENSITY_SMALL = 1'b0, // Main array needs only 24 bits
  parameter logic [7:0] OPC_READ = `SFAE_OPC_READ,
  parameter logic [7:0] OPC_PROG = `SFAE_OPC_PROG,
  parameter logic [7:0] OPC_READ4 = `SFAE_OPC_READ4,
  parameter logic [7:0] OPC_PROG4 = `SFAE_OPC_PROG4,
  parameter logic [7:0] OPC_OTP_READ = `SFAE_OPC_OTP_READ,
  parameter logic [7:0] OPC_OTP_PROG = `SFAE_OPC_OTP_PROG,
  parameter logic [7:0] OPC_BANK_WR = `SFAE_OPC_BANK_WR,
  parameter logic [7:0] OPC_BANK_RD = `SFAE_OPC_BANK_RD
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input sfae_link_s link_in,
  output sfae_cmd_s cmd_out,
  output logic so_out,
  output logic so_oe_out,
  output logic [7:0] bank_out,
  output logic ext_mode_out
);

  sfae_state_s q_q; // Registered state
  sfae_state_s q_d; // Next state
  sfae_link_s link_s; // Synchronised pins
  logic sck_rise; // Host sampling edge
  logic sck_fall; // Host launch edge
  logic [31:0] stream; // Shift register with the current bit
  logic [7:0] byte_now; // Low byte of the stream
  logic is_legacy; // Address width follows the mode bit
  logic is_new; // Address always four bytes
  logic is_otp; // One-time space command
  logic [31:0] eff_addr; // Formed effective address

  // Pins cross into clk_in before any decode
  sfae_sync #(
    .W(3),
    .RST_VAL(`SFAE_LINK_IDLE)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(link_in),
    .q_out(link_s)
  );

  // Edges of the sampled link clock
  assign sck_rise = link_s.sck & ~q_q.sck_prev;
  assign sck_fall = ~link_s.sck & q_q.sck_prev;
  assign stream = {q_q.shreg[30:0], link_s.si};
  assign byte_now = stream[7:0];

  // Command classes, by the opcode held in the state
  assign is_legacy = (q_q.opcode == OPC_READ) || (q_q.opcode == OPC_PROG) ||
                     is_otp;
  assign is_new = (q_q.opcode == OPC_READ4) || (q_q.opcode == OPC_PROG4);
  assign is_otp = (q_q.opcode == OPC_OTP_READ) || (q_q.opcode == OPC_OTP_PROG);

  // Effective address from the received bits and the bank
  always_comb begin
    if (q_q.last_bit == `SFAE_LAST_ADDR24) begin
      eff_addr = {1'b0, q_q.bank[6:0], stream[`SFAE_LO_MSB:0]};
    end else begin
      eff_addr = stream;
    end
    // Small density drops the high byte only in the main array
    if (DENSITY_SMALL && !is_otp) begin
      eff_addr[`SFAE_HI_MSB:`SFAE_HI_LSB] = `SFAE_HI_ZERO;
    end
  end

  // Next state of the whole decoder
  always_comb begin
    q_d = q_q;
    q_d.cmd.valid = 1'b0;
    q_d.sck_prev = link_s.sck;
    if (link_s.cs_n) begin
      // Deselect ends any frame and frees the output
      q_d.phase = SFAE_OPC;
      q_d.bitcnt = '0;
      q_d.so_oe = 1'b0;
    end else if (sck_rise) begin
      q_d.shreg = stream;
      q_d.bitcnt = q_q.bitcnt + 5'd1;
      unique case (q_q.phase)
        SFAE_OPC: begin
          if (q_q.bitcnt == `SFAE_LAST_BYTE) begin
            q_d.opcode = byte_now;
            q_d.bitcnt = '0;
            q_d.phase = SFAE_ADDR;
            // Width fixed at opcode time; mode bit cannot move mid-frame
            if (byte_now == OPC_READ4 || byte_now == OPC_PROG4) begin
              q_d.last_bit = `SFAE_LAST_ADDR32;
            end else if (q_q.bank[`SFAE_EXT_BIT]) begin
              q_d.last_bit = `SFAE_LAST_ADDR32;
            end else begin
              q_d.last_bit = `SFAE_LAST_ADDR24;
            end
            if (byte_now == OPC_BANK_WR) begin
              q_d.phase = SFAE_BANK_IN;
            end else if (byte_now == OPC_BANK_RD) begin
              q_d.phase = SFAE_BANK_OUT;
              q_d.shout = q_q.bank;
            end else if (!(byte_now == OPC_READ || byte_now == OPC_PROG ||
                           byte_now == OPC_READ4 || byte_now == OPC_PROG4 ||
                           byte_now == OPC_OTP_READ || byte_now == OPC_OTP_PROG)) begin
              // Unknown codes are ignored until deselect
              q_d.phase = SFAE_SKIP;
            end
          end
        end
        SFAE_ADDR: begin
          if (q_q.bitcnt == q_q.last_bit) begin
            q_d.cmd.valid = 1'b1;
            q_d.cmd.opcode = q_q.opcode;
            q_d.cmd.space = is_otp ? SFAE_OTP : SFAE_MAIN;
            q_d.cmd.wide = (q_q.last_bit == `SFAE_LAST_ADDR32);
            q_d.cmd.addr = eff_addr;
            q_d.cmd.otp_ok = is_otp && (eff_addr < `SFAE_OTP_SIZE);
            q_d.phase = SFAE_SKIP; // Data bytes belong to the array logic
          end
        end
        SFAE_BANK_IN: begin
          if (q_q.bitcnt == `SFAE_LAST_BYTE) begin
            q_d.bank = byte_now;
            q_d.phase = SFAE_SKIP;
          end
        end
        SFAE_BANK_OUT: begin
          // Output shifts on the falling edge only
        end
        SFAE_SKIP: begin
          // Remaining bits of the frame are not ours
        end
      endcase
    end else if (sck_fall && q_q.phase == SFAE_BANK_OUT) begin
      // Rotate so repeated reads repeat the bank image
      q_d.so = q_q.shout[7];
      q_d.shout = {q_q.shout[6:0], q_q.shout[7]};
      q_d.so_oe = 1'b1;
    end
  end

  // State register; bank and mode reset to the 24-bit default
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_q <= '0;
      q_q.phase <= SFAE_OPC;
      q_q.bank <= `SFAE_BANK_RESET;
      q_q.last_bit <= `SFAE_LAST_ADDR24;
      q_q.sck_prev <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  // Outputs straight from the state
  assign cmd_out = q_q.cmd;
  assign so_out = q_q.so;
  assign so_oe_out = q_q.so_oe;
  assign bank_out = q_q.bank;
  assign ext_mode_out = q_q.bank[`SFAE_EXT_BIT];

  // Bank leaves reset cleared
  a_reset_bank_clear: assert property (@(posedge clk_in)
    $fell(rst_in) |-> (q_q.bank == `SFAE_BANK_RESET && !q_q.bank[`SFAE_EXT_BIT]))
    else $error("bank not cleared at reset");

  // Bank only changes by its own load command
  a_bank_load_only: assert property (@(posedge clk_in) disable iff (rst_in)
    $changed(q_q.bank) |-> $past(q_q.phase) == SFAE_BANK_IN)
    else $error("bank changed outside its load");

  // Legacy commands in 24-bit mode are narrow with bank on top
  a_legacy_bank_top: assert property (@(posedge clk_in) disable iff (rst_in)
    (q_q.cmd.valid && !q_q.cmd.wide && !DENSITY_SMALL) |->
      q_q.cmd.addr[`SFAE_HI_MSB:`SFAE_HI_LSB] == {1'b0, q_q.bank[6:0]})
    else $error("bank bits not above narrow address");

  // Legacy width follows the mode bit
  a_legacy_width_mode: assert property (@(posedge clk_in) disable iff (rst_in)
    (q_q.cmd.valid && (q_q.cmd.opcode == OPC_READ || q_q.cmd.opcode == OPC_PROG)) |->
      (q_q.cmd.wide == q_q.bank[`SFAE_EXT_BIT]))
    else $error("legacy width disagrees with mode");

  // Newer commands are always wide
  a_new_always_wide: assert property (@(posedge clk_in) disable iff (rst_in)
    (q_q.cmd.valid && (q_q.cmd.opcode == OPC_READ4 || q_q.cmd.opcode == OPC_PROG4)) |->
      q_q.cmd.wide)
    else $error("newer command took narrow address");

  // A strobed command is either width-following or fixed four-byte, never both
  a_single_class: assert property (@(posedge clk_in) disable iff (rst_in)
    q_q.cmd.valid |-> (is_legacy != is_new))
    else $error("command class ambiguous");

  // Small density masks the high byte of main addresses
  a_small_high_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (q_q.cmd.valid && q_q.cmd.space == SFAE_MAIN && DENSITY_SMALL) |->
      q_q.cmd.addr[`SFAE_HI_MSB:`SFAE_HI_LSB] == `SFAE_HI_ZERO)
    else $error("high byte kept in small density");

  // One-time range flag matches the full address
  a_otp_range_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (q_q.cmd.valid && q_q.cmd.space == SFAE_OTP) |->
      q_q.cmd.otp_ok == (q_q.cmd.addr < `SFAE_OTP_SIZE))
    else $error("one-time range flag wrong");

  // Strobe is a single cycle and follows a selected clock edge
  a_cmd_strobe_once: assert property (@(posedge clk_in) disable iff (rst_in)
    q_q.cmd.valid |-> !$past(link_s.cs_n) ##1 !q_q.cmd.valid)
    else $error("command strobe malformed");

  // Deselect ends the frame and releases the output
  a_deselect_idle: assert property (@(posedge clk_in) disable iff (rst_in)
    link_s.cs_n |=> (q_q.phase == SFAE_OPC && !q_q.so_oe))
    else $error("frame survived deselect");

endmodule : sfae_core

//--- testbench/sfae_host.sv
// Host controller model driving the serial link in mode 0.
// Assumes clk_in is the 40 MHz bench clock; link clock is 200 ns.
`timescale 1ns/100ps
module sfae_host
  import sfae_pkg::*;
(
  input wire logic clk_in,
  input wire logic so_in,
  output sfae_link_s link_out
);
  // Link idles deselected with the clock low
  initial link_out = 3'b010;

  // Half a link period, four bench cycles
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask : half

  // One frame: opcode then n bits of data, MSB first
  task automatic xfer(input logic [7:0] op, input logic [31:0] data, input int n,
                      output logic [7:0] rd);
    logic [39:0] bits;
    bits = {op, data << (32 - n)};
    rd = 8'h00;
    @(negedge clk_in);
    link_out.cs_n = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      link_out.si = bits[39 - i];
      half();
      link_out.sck = 1'b1;
      half();
      // Sampled late in the high phase to allow for sync latency
      rd = {rd[6:0], so_in};
      link_out.sck = 1'b0;
    end
    half();
    link_out.cs_n = 1'b1;
    // Released line must not keep showing the last bit
    link_out.si = ~link_out.si;
  endtask : xfer
endmodule : sfae_host

//--- testbench/tb.sv
// Self-checking bench for the address extension core.
// Assumes the host model above; a second core sees the same link.
`timescale 1ns/100ps
module tb;
  import sfae_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  sfae_link_s link;
  sfae_cmd_s cmd, cmd2, cap, cap2; // Live and captured commands
  logic so, so_oe, ext;
  logic [7:0] bank, rd;
  int n_errors = 0;
  int checked = 0;
  int n_valid = 0; // Strobes seen on the main core
  logic oe_seen = 1'b0; // Output enable seen during a bank read

  // Bench clock, 25 ns period
  always #12.5 clk_in = ~clk_in;

  sfae_host sfae_host_i(.clk_in(clk_in), .so_in(so), .link_out(link));
  sfae_core sfae_core_i(.clk_in(clk_in), .rst_in(rst_in), .link_in(link), .cmd_out(cmd),
    .so_out(so), .so_oe_out(so_oe), .bank_out(bank), .ext_mode_out(ext));
  // Small density variant, output pins left open
  sfae_core #(.DENSITY_SMALL(1'b1)) sfae_core_small_i(.clk_in(clk_in), .rst_in(rst_in),
    .link_in(link), .cmd_out(cmd2), .so_out(), .so_oe_out(), .bank_out(),
    .ext_mode_out());

  // Capture each one-cycle strobe mid-cycle, where it is settled
  always @(negedge clk_in) begin
    if (cmd.valid === 1'b1) begin
      cap <= cmd;
      n_valid <= n_valid + 1;
    end
    if (so_oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
    if (cmd2.valid === 1'b1) begin
      cap2 <= cmd2;
    end
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Frame plus settling time for the synchroniser
  task automatic frame(input logic [7:0] op, input logic [31:0] d, input int n);
    sfae_host_i.xfer(op, d, n, rd);
    repeat (8) @(negedge clk_in);
  endtask : frame

  task automatic t_reset();
    chk("bank", bank, 32'h0);
    chk("ext", ext, 32'h0);
    chk("so_oe", so_oe, 32'h0);
  endtask : t_reset

  // Legacy commands in 24-bit mode with bank zero
  task automatic t_legacy();
    logic [7:0] ops[2] = '{8'h03, 8'h02};
    foreach (ops[i]) begin
      frame(ops[i], 32'h0012_3456, 24);
      chk("opcode", cap.opcode, ops[i]);
      chk("addr", cap.addr, 32'h0012_3456);
      chk("wide", cap.wide, 32'h0);
      chk("space", cap.space, SFAE_MAIN);
    end
  endtask : t_legacy

  // Bank supplies the upper byte; small part drops it
  task automatic t_bank();
    frame(8'h17, 32'h05, 8);
    chk("bank", bank, 32'h05);
    frame(8'h03, 32'h00AB_CDEF, 24);
    chk("addr", cap.addr, 32'h05AB_CDEF);
    chk("small", cap2.addr, 32'h00AB_CDEF);
  endtask : t_bank

  // Four-byte commands ignore the mode bit
  task automatic t_wide();
    logic [7:0] ops[2] = '{8'h13, 8'h12};
    foreach (ops[i]) begin
      frame(ops[i], 32'h89AB_CDEF, 32);
      chk("addr", cap.addr, 32'h89AB_CDEF);
      chk("wide", cap.wide, 32'h1);
      chk("small", cap2.addr, 32'h00AB_CDEF);
    end
  endtask : t_wide

  // Mode bit set: legacy needs 32 bits, short address refused
  task automatic t_ext();
    int v;
    frame(8'h17, 32'h81, 8);
    chk("ext", ext, 32'h1);
    frame(8'h03, 32'hFEDC_BA98, 32);
    chk("addr", cap.addr, 32'hFEDC_BA98);
    v = n_valid;
    frame(8'h02, 32'h0012_3456, 24);
    chk("strobes", n_valid, v);
    frame(8'hA5, 32'h0012_3456, 32);
    chk("strobes", n_valid, v);
    frame(8'h16, 32'h0, 8);
    chk("bank_rd", rd, 32'h81);
    chk("oe_seen", oe_seen, 32'h1);
    chk("so_oe", so_oe, 32'h0);
  endtask : t_ext

  // One-time space: bounds flag, never masked
  task automatic t_otp();
    frame(8'h4B, 32'h0000_03FF, 32);
    chk("space", cap.space, SFAE_OTP);
    chk("otp_ok", cap.otp_ok, 32'h1);
    frame(8'h42, 32'h1200_0400, 32);
    chk("otp_ok", cap.otp_ok, 32'h0);
    chk("small", cap2.addr, 32'h1200_0400);
  endtask : t_otp

  // Reset in mid-run returns to 24-bit mode, bank zero
  task automatic t_rst();
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset();
    frame(8'h03, 32'h0000_0010, 24);
    chk("addr", cap.addr, 32'h0000_0010);
  endtask : t_rst

  // Main sequence
  initial begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset();
    t_legacy();
    t_bank();
    t_wide();
    t_ext();
    t_otp();
    t_rst();
    end_of_test();
  end

  // Watchdog, well past the roughly 95 us of traffic
  initial begin
    #500000;
    n_errors++;
    end_of_test();
  end
endmodule : tb
